// ### verilog/rtc_map.vh
// Register map, field positions, reset values and sync counts of the real-time counter.
`ifndef RTC_MAP_VH
`define RTC_MAP_VH
// Register indices; the byte address on the bus is four times the index.
`define IDX_MAIN_CTRL 5'h00
`define IDX_SYNC_STATE 5'h01
`define IDX_EVENT_ENABLES 5'h02
`define IDX_EVENT_FLAGS 5'h03
`define IDX_WIDE_LATCH 5'h04
`define IDX_HALT_BEHAVIOUR 5'h05
`define IDX_SOURCE_SELECT 5'h07
`define IDX_COUNT_LO 5'h08
`define IDX_COUNT_HI 5'h09
`define IDX_LIMIT_LO 5'h0A
`define IDX_LIMIT_HI 5'h0B
`define IDX_MATCH_LO 5'h0C
`define IDX_MATCH_HI 5'h0D
`define IDX_TICK_CONTROL 5'h10
`define IDX_TICK_SYNC_STATE 5'h11
`define IDX_EVENT_CLEAR 5'h16
// Field positions.
`define BIT_WRAP_EVENT 0
`define BIT_MATCH_EVENT 1
`define BIT_COUNTER_ON 0
`define PRESCALE_LSB 3
`define PRESCALE_MSB 6
`define BIT_RUN_WHILE_HALTED 0
`define BIT_TICK_TIMER_ON 0
`define INTERVAL_LSB 3
`define INTERVAL_MSB 6
// Reset values.
`define RST_BYTE 8'h00
`define RST_COUNT 16'h0000
`define RST_LIMIT 16'hFFFF
`define RST_MATCH 16'h0000
// Interval codes with no tick.
`define INTERVAL_OFF 4'h0
`define INTERVAL_RESERVED 4'hF
// Counter-clock edges between a register write and its effect.
`define SYNC_STAGES 2'h2
// Bus answers.
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// ### verilog/edge_sync.v
// Two-flop synchroniser with rising-edge pulses for a group of pin levels.
`timescale 1ns/1ps
`default_nettype none
module edge_sync #(
  parameter W = 5
) (
  input wire clk_i,
  input wire rst_n_i,
  input wire [W-1:0] d_i,
  output wire [W-1:0] q_o,
  output wire [W-1:0] rise_o
);
  reg [W-1:0] meta_r;
  reg [W-1:0] sync_r;
  reg [W-1:0] prev_r;

  // The first stage feeds only the second; edge detection looks at later stages.
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_r <= {W{1'b0}};
      sync_r <= {W{1'b0}};
      prev_r <= {W{1'b0}};
    end else begin
      meta_r <= d_i;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  // One-cycle pulse on each rising level.
  assign q_o = sync_r;
  assign rise_o = sync_r & ~prev_r;
endmodule // edge_sync
`default_nettype wire

// ### verilog/prescale_tap.v
// Free-running binary divider that emits one pulse every 2^code enable pulses.
`timescale 1ns/1ps
`default_nettype none
module prescale_tap (
  input wire clk_i,
  input wire rst_n_i,
  input wire en_i,
  input wire clr_i,
  input wire [3:0] code_i,
  output wire tick_o
);
  reg [14:0] cnt_r;
  wire [14:0] low_ones;

  // Bit i only matters when the division needs it, so code 0 passes every pulse.
  genvar i;
  generate
    for (i = 0; i < 15; i = i + 1) begin : g_tap
      localparam [3:0] POS = i;
      assign low_ones[i] = cnt_r[i] | (code_i <= POS);
    end
  endgenerate

  // Counting from a cleared state keeps the first period full length.
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_r <= 15'h0000;
    end else if (clr_i) begin
      cnt_r <= 15'h0000;
    end else if (en_i) begin
      cnt_r <= cnt_r + 15'h0001;
    end
  end

  assign tick_o = en_i & (&low_ones);
endmodule // prescale_tap
`default_nettype wire

// ### verilog/rtc_core.v
// Real-time counter with wrap and match events, periodic tick and AXI4-Lite registers.
`timescale 1ns/1ps
`default_nettype none
`include "rtc_map.vh"
module rtc_core (
  input wire clk_i,
  input wire resetn_i,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output wire [1:0] s_axi_bresp,
  output wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0] s_axi_rresp,
  output wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire slow_osc_i,
  input wire khz_tap_i,
  input wire crystal_i,
  input wire ext_pin_i,
  input wire cpu_halted_i,
  output wire irq_o,
  output wire tick_o
);
  reg [1:0] rst_sync_r;
  wire rst_n;
  wire [4:0] pin_lvl;
  wire [4:0] pin_rise;
  wire src_edge;
  // Software-visible configuration.
  reg [7:0] main_ctrl_r;
  reg [7:0] main_ctrl_act_r;
  reg [1:0] event_enables_r;
  reg [1:0] event_flags_r;
  reg [1:0] event_flags_nxt;
  reg [7:0] temp_r;
  reg halt_behaviour_r;
  reg [1:0] source_select_r;
  reg [15:0] count_r;
  reg [15:0] count_sh_r;
  reg [15:0] limit_r;
  reg [15:0] limit_sh_r;
  reg [15:0] match_r;
  reg [15:0] match_sh_r;
  reg [7:0] tick_control_r;
  reg [7:0] tick_act_r;
  // Synchronisation of items: 0 control, 1 count, 2 limit, 3 match, 4 tick control.
  reg [4:0] pend_r;
  reg [9:0] stage_r;
  wire [4:0] wr_item;
  wire [4:0] apply;
  // Bus state.
  reg awready_r;
  reg wready_r;
  reg aw_held_r;
  reg w_held_r;
  reg [4:0] wr_idx_r;
  reg [7:0] wr_data_r;
  reg wr_lane_r;
  reg bvalid_r;
  reg [1:0] bresp_r;
  reg arready_r;
  reg rvalid_r;
  reg [7:0] rdata_r;
  reg [1:0] rresp_r;
  reg [7:0] rd_byte;
  reg rd_ok;
  reg wr_ok;
  wire do_wr;
  wire wen;
  wire rd_take;
  wire [4:0] rd_idx;
  // Counter datapath.
  wire run;
  wire cnt_tick;
  wire at_limit;
  wire [15:0] count_inc;
  wire [1:0] evt_set;
  wire [1:0] evt_clr;
  wire tick_ok;
  wire [3:0] interval;
  wire pit_hit;
  reg irq_r;
  reg tick_r;

  // Reset asserts at once and releases through two flops.
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_sync_r <= 2'b00;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];

  // Source pins and the halt level come from outside this clock's domain.
  edge_sync #(.W(5)) u_pins (
    .clk_i(clk_i),
    .rst_n_i(rst_n),
    .d_i({cpu_halted_i, ext_pin_i, crystal_i, khz_tap_i, slow_osc_i}),
    .q_o(pin_lvl),
    .rise_o(pin_rise)
  );

  // Each rising edge of the selected source is one counter-clock cycle.
  assign src_edge = pin_rise[source_select_r];
  assign run = ~pin_lvl[4] | halt_behaviour_r;

  // Prescaler divides the counter clock before the counter sees it.
  prescale_tap u_prescale (
    .clk_i(clk_i),
    .rst_n_i(rst_n),
    .en_i(src_edge & run & main_ctrl_act_r[`BIT_COUNTER_ON]),
    .clr_i(~main_ctrl_act_r[`BIT_COUNTER_ON]),
    .code_i(main_ctrl_act_r[`PRESCALE_MSB:`PRESCALE_LSB]),
    .tick_o(cnt_tick)
  );

  // Interval n ticks every 2^(n+1) source edges; off and reserved codes stop it.
  assign interval = tick_act_r[`INTERVAL_MSB:`INTERVAL_LSB];
  assign tick_ok = tick_act_r[`BIT_TICK_TIMER_ON] & (interval != `INTERVAL_OFF) &
                   (interval != `INTERVAL_RESERVED);
  prescale_tap u_tick (
    .clk_i(clk_i),
    .rst_n_i(rst_n),
    .en_i(src_edge & tick_ok),
    .clr_i(~tick_ok),
    .code_i(interval + 4'h1),
    .tick_o(pit_hit)
  );

  // Bus write happens once both address and data are held.
  assign do_wr = aw_held_r & w_held_r & ~bvalid_r;
  assign wen = do_wr & wr_lane_r;
  assign wr_item[0] = wen & (wr_idx_r == `IDX_MAIN_CTRL);
  assign wr_item[1] = wen & (wr_idx_r == `IDX_COUNT_HI);
  assign wr_item[2] = wen & (wr_idx_r == `IDX_LIMIT_HI);
  assign wr_item[3] = wen & (wr_idx_r == `IDX_MATCH_HI);
  assign wr_item[4] = wen & (wr_idx_r == `IDX_TICK_CONTROL);

  // A written value waits two counter-clock edges before it reaches the active copy.
  // Rewriting while busy restarts the wait, which is why software must poll busy.
  genvar g;
  generate
    for (g = 0; g < 5; g = g + 1) begin : g_sync
      assign apply[g] = pend_r[g] & src_edge & (stage_r[2*g+1:2*g] == 2'h1);
      always @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
          pend_r[g] <= 1'b0;
          stage_r[2*g+1:2*g] <= 2'h0;
        end else if (wr_item[g]) begin
          pend_r[g] <= 1'b1;
          stage_r[2*g+1:2*g] <= `SYNC_STAGES;
        end else if (pend_r[g] & src_edge) begin
          pend_r[g] <= ~apply[g];
          stage_r[2*g+1:2*g] <= stage_r[2*g+1:2*g] - 2'h1;
        end
      end
    end
  endgenerate

  // Counter steps per prescaled tick and reloads zero after equalling the limit.
  assign at_limit = (count_r == limit_r);
  assign count_inc = at_limit ? 16'h0000 : count_r + 16'h0001;
  assign evt_set[`BIT_WRAP_EVENT] = cnt_tick & at_limit & ~apply[1];
  assign evt_set[`BIT_MATCH_EVENT] = cnt_tick & ~apply[1] & (count_inc == match_r);
  assign evt_clr = (wen & ((wr_idx_r == `IDX_EVENT_FLAGS) | (wr_idx_r == `IDX_EVENT_CLEAR))) ?
                   wr_data_r[1:0] : 2'b00;

  // A set in the clearing cycle wins so no event is lost.
  always @* begin
    event_flags_nxt = (event_flags_r & ~evt_clr) | evt_set;
  end

  // Active copies of synchronised registers and the live count.
  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      main_ctrl_act_r <= `RST_BYTE;
      count_r <= `RST_COUNT;
      limit_r <= `RST_LIMIT;
      match_r <= `RST_MATCH;
      tick_act_r <= `RST_BYTE;
      event_flags_r <= 2'b00;
      irq_r <= 1'b0;
      tick_r <= 1'b0;
    end else begin
      if (apply[0]) begin
        main_ctrl_act_r <= main_ctrl_r;
      end
      if (apply[1]) begin
        count_r <= count_sh_r;
      end else if (cnt_tick) begin
        count_r <= count_inc;
      end
      if (apply[2]) begin
        limit_r <= limit_sh_r;
      end
      if (apply[3]) begin
        match_r <= match_sh_r;
      end
      if (apply[4]) begin
        tick_act_r <= tick_control_r;
      end
      event_flags_r <= event_flags_nxt;
      irq_r <= |(event_flags_nxt & event_enables_r);
      tick_r <= pit_hit;
    end
  end

  // Software-written copies; 16-bit values commit on the high byte with the latched low.
  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      main_ctrl_r <= `RST_BYTE;
      event_enables_r <= 2'b00;
      halt_behaviour_r <= 1'b0;
      source_select_r <= 2'b00;
      count_sh_r <= `RST_COUNT;
      limit_sh_r <= `RST_LIMIT;
      match_sh_r <= `RST_MATCH;
      tick_control_r <= `RST_BYTE;
    end else if (wen) begin
      case (wr_idx_r)
        `IDX_MAIN_CTRL: main_ctrl_r <= {wr_data_r[7:3], 2'b00, wr_data_r[0]};
        `IDX_EVENT_ENABLES: event_enables_r <= wr_data_r[1:0];
        `IDX_HALT_BEHAVIOUR: halt_behaviour_r <= wr_data_r[`BIT_RUN_WHILE_HALTED];
        `IDX_SOURCE_SELECT: source_select_r <= wr_data_r[1:0];
        `IDX_COUNT_HI: count_sh_r <= {wr_data_r, temp_r};
        `IDX_LIMIT_HI: limit_sh_r <= {wr_data_r, temp_r};
        `IDX_MATCH_HI: match_sh_r <= {wr_data_r, temp_r};
        `IDX_TICK_CONTROL: tick_control_r <= {1'b0, wr_data_r[6:3], 2'b00, wr_data_r[0]};
        default: main_ctrl_r <= main_ctrl_r;
      endcase
    end
  end

  // Reads of a low byte latch the high byte so a following high read is coherent.
  assign rd_idx = s_axi_araddr[6:2];
  assign rd_take = s_axi_arvalid & arready_r;
  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      temp_r <= `RST_BYTE;
    end else if (wen & ((wr_idx_r == `IDX_COUNT_LO) | (wr_idx_r == `IDX_LIMIT_LO) |
                        (wr_idx_r == `IDX_MATCH_LO) | (wr_idx_r == `IDX_WIDE_LATCH))) begin
      temp_r <= wr_data_r;
    end else if (rd_take & (rd_idx == `IDX_COUNT_LO) & ~s_axi_araddr[7]) begin
      temp_r <= count_r[15:8];
    end else if (rd_take & (rd_idx == `IDX_LIMIT_LO) & ~s_axi_araddr[7]) begin
      temp_r <= limit_sh_r[15:8];
    end else if (rd_take & (rd_idx == `IDX_MATCH_LO) & ~s_axi_araddr[7]) begin
      temp_r <= match_sh_r[15:8];
    end
  end

  // Read decode; high bytes of 16-bit registers return the latch.
  always @* begin
    rd_byte = 8'h00;
    rd_ok = ~s_axi_araddr[7];
    case (rd_idx)
      `IDX_MAIN_CTRL: rd_byte = main_ctrl_r;
      `IDX_SYNC_STATE: rd_byte = {4'h0, pend_r[3:0]};
      `IDX_EVENT_ENABLES: rd_byte = {6'h00, event_enables_r};
      `IDX_EVENT_FLAGS: rd_byte = {6'h00, event_flags_r};
      `IDX_WIDE_LATCH: rd_byte = temp_r;
      `IDX_HALT_BEHAVIOUR: rd_byte = {7'h00, halt_behaviour_r};
      `IDX_SOURCE_SELECT: rd_byte = {6'h00, source_select_r};
      `IDX_COUNT_LO: rd_byte = count_r[7:0];
      `IDX_LIMIT_LO: rd_byte = limit_sh_r[7:0];
      `IDX_MATCH_LO: rd_byte = match_sh_r[7:0];
      `IDX_COUNT_HI: rd_byte = temp_r;
      `IDX_LIMIT_HI: rd_byte = temp_r;
      `IDX_MATCH_HI: rd_byte = temp_r;
      `IDX_TICK_CONTROL: rd_byte = tick_control_r;
      `IDX_TICK_SYNC_STATE: rd_byte = {7'h00, pend_r[4]};
      `IDX_EVENT_CLEAR: rd_byte = 8'h00;
      default: rd_ok = 1'b0;
    endcase
  end

  // Writable indices; the flag, clear and enable registers are among them.
  always @* begin
    case (wr_idx_r)
      `IDX_MAIN_CTRL, `IDX_EVENT_ENABLES, `IDX_EVENT_FLAGS, `IDX_WIDE_LATCH: wr_ok = 1'b1;
      `IDX_HALT_BEHAVIOUR, `IDX_SOURCE_SELECT, `IDX_COUNT_LO, `IDX_COUNT_HI: wr_ok = 1'b1;
      `IDX_LIMIT_LO, `IDX_LIMIT_HI, `IDX_MATCH_LO, `IDX_MATCH_HI: wr_ok = 1'b1;
      `IDX_TICK_CONTROL, `IDX_EVENT_CLEAR: wr_ok = 1'b1;
      default: wr_ok = 1'b0;
    endcase
  end

  // Write channels are taken independently and answered once both are in.
  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      awready_r <= 1'b0;
      wready_r <= 1'b0;
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      wr_idx_r <= 5'h00;
      wr_data_r <= 8'h00;
      wr_lane_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= `RESP_OKAY;
    end else begin
      if (s_axi_awvalid & awready_r) begin
        aw_held_r <= 1'b1;
        awready_r <= 1'b0;
        wr_idx_r <= s_axi_awaddr[7] ? 5'h1F : s_axi_awaddr[6:2];
      end else if (~aw_held_r & ~bvalid_r) begin
        awready_r <= 1'b1;
      end
      if (s_axi_wvalid & wready_r) begin
        w_held_r <= 1'b1;
        wready_r <= 1'b0;
        wr_data_r <= s_axi_wdata[7:0];
        wr_lane_r <= s_axi_wstrb[0];
      end else if (~w_held_r & ~bvalid_r) begin
        wready_r <= 1'b1;
      end
      if (do_wr) begin
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
      end else if (bvalid_r & s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // Read answers one cycle after the address is taken and holds until accepted.
  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rdata_r <= 8'h00;
      rresp_r <= `RESP_OKAY;
    end else if (rd_take) begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b1;
      rdata_r <= rd_byte;
      rresp_r <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
    end else if (rvalid_r & s_axi_rready) begin
      rvalid_r <= 1'b0;
      arready_r <= 1'b1;
    end else if (~rvalid_r) begin
      arready_r <= 1'b1;
    end
  end

  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = {24'h000000, rdata_r};
  assign s_axi_rresp = rresp_r;
  assign irq_o = irq_r;
  assign tick_o = tick_r;
endmodule // rtc_core
`default_nettype wire

// ### tb/rtc_core_monitor.sv
// Concurrent checks on the register bus and tick output of the real-time counter.
`timescale 1ns/1ps
`default_nettype none
`include "rtc_map.vh"
module rtc_core_monitor (
  input wire clk_i,
  input wire resetn_i,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire tick_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!resetn_i);
  // A write is taken when address and data are accepted at the same edge.
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  a_write_answer: assert property (wr_taken |-> ##[1:2] s_axi_bvalid)
    else $error("write response late");
  a_read_answer: assert property (rd_taken |=> s_axi_rvalid)
    else $error("read data late");
  a_unmapped_err: assert property (wr_taken ##0 s_axi_awaddr[7] |-> ##[1:2]
    (s_axi_bvalid && s_axi_bresp == `RESP_SLVERR)) else $error("unmapped write not refused");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_rdata_byte: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("upper read bits not zero");
  a_write_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
  // Ticks are at least four source edges apart, so no closer than eight clocks.
  a_tick_pulse: assert property (tick_o |=> !tick_o [*8])
    else $error("tick pulse too long or too close");
endmodule // rtc_core_monitor
`default_nettype wire

// ### tb/testbench.sv
// Self-checking testbench for the real-time counter register block.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h00000000;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, cpu_halted_i = 1'b0;
  logic slow_osc_i = 1'b0, khz_tap_i = 1'b0, crystal_i = 1'b0, ext_pin_i = 1'b0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq_o, tick_o;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  int bad_count = 0;
  int check_count = 0;
  int cycles = 0;
  int ticks = 0;
  logic [1:0] resp;
  logic [7:0] rd, c;
  logic [15:0] cnt;
  logic [7:0] ra [12] = '{8'h0C, 8'h10, 8'h14, 8'h1C, 8'h20, 8'h24, 8'h28, 8'h2C, 8'h30,
    8'h34, 8'h40, 8'h44};
  logic [7:0] re [12] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'h00,
    8'h00, 8'h00, 8'h00};
  logic [3:0] tc [3] = '{4'h1, 4'h2, 4'hF};
  logic [7:0] te [3] = '{8'h04, 8'h02, 8'h00};

  rtc_core u_rtc_core (.*);

  always #2.5 clk_i = ~clk_i;

  // Counts tick pulses and cuts a hang short well beyond the expected run length.
  always @(posedge clk_i) begin
    cycles = cycles + 1;
    if (tick_o === 1'b1) ticks = ticks + 1;
    if (cycles == 6000) begin
      bad_count = bad_count + 1;
      final_report();
    end
  end

  task final_report;
    if (bad_count == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task chk(input string n, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      $display("MISMATCH %s expected %h seen %h", n, e, g);
      bad_count++;
    end
  endtask

  // Address and data are offered together; each is released at its own handshake edge.
  task wr(input logic [7:0] a, input logic [7:0] d);
    logic aw, w;
    aw = 1'b1;
    w = 1'b1;
    @(posedge clk_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk_i);
      if (aw && s_axi_awready) begin
        aw = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (w && s_axi_wready) begin
        w = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end while (s_axi_bvalid !== 1'b1);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task rdb(input logic [7:0] a);
    @(posedge clk_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk_i);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata[7:0];
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  // The low byte goes first so the high byte commits both halves at once.
  task wr16(input logic [7:0] a, input logic [15:0] v);
    wr(a, v[7:0]);
    wr(a + 8'h04, v[15:8]);
  endtask

  task rd16(input logic [7:0] a);
    rdb(a);
    cnt[7:0] = rd;
    rdb(a + 8'h04);
    cnt[15:8] = rd;
  endtask

  task pin(input int s, input logic v);
    case (s)
      0: slow_osc_i <= v;
      1: khz_tap_i <= v;
      2: crystal_i <= v;
      default: ext_pin_i <= v;
    endcase
  endtask

  // Each source edge stays high and low long enough for the two-flop synchroniser.
  task edges(input int s, input int n);
    repeat (n) begin
      @(posedge clk_i);
      pin(s, 1'b1);
      repeat (3) @(posedge clk_i);
      pin(s, 1'b0);
      repeat (2) @(posedge clk_i);
    end
    repeat (4) @(posedge clk_i);
  endtask

  initial begin
    repeat (6) @(posedge clk_i);
    resetn_i <= 1'b1;
    for (int i = 0; i < 12; i++) begin
      rdb(ra[i]);
      chk("reset value", re[i], rd);
    end
    wr(8'h80, 8'h5A);
    chk("unmapped resp", 8'h02, {6'h00, resp});
    // A read of a reserved index must be refused on the response code.
    rdb(8'h18);
    chk("unmapped read resp", 8'h02, {6'h00, resp});
    wr(8'h10, 8'hA5);
    rdb(8'h10);
    chk("latch", 8'hA5, rd);
    wr16(8'h28, 16'h0003);
    wr16(8'h30, 16'h0002);
    wr(8'h00, 8'h01);
    wr(8'h08, 8'h03);
    rdb(8'h04);
    chk("busy set", 8'h0D, rd);
    edges(0, 2);
    rdb(8'h04);
    chk("busy clear", 8'h00, rd);
    rd16(8'h20);
    edges(0, 3 - int'(cnt[1:0]));
    rdb(8'h0C);
    chk("match flag", 8'h02, rd);
    chk("match irq", 8'h01, {7'h00, irq_o});
    wr(8'h0C, 8'h02);
    rdb(8'h0C);
    chk("match cleared", 8'h00, rd);
    edges(0, 1);
    rdb(8'h0C);
    chk("wrap flag", 8'h01, rd);
    wr(8'h0C, 8'h00);
    rdb(8'h0C);
    chk("zero write", 8'h01, rd);
    wr(8'h08, 8'h02);
    rdb(8'h08);
    chk("wrap irq masked", 8'h00, {7'h00, irq_o});
    wr(8'h08, 8'h01);
    rdb(8'h08);
    chk("wrap irq", 8'h01, {7'h00, irq_o});
    wr(8'h58, 8'h01);
    rdb(8'h0C);
    chk("flags cleared", 8'h00, rd);
    chk("irq cleared", 8'h00, {7'h00, irq_o});
    // A count write lands only at the second source edge.
    wr16(8'h20, 16'h0005);
    rdb(8'h04);
    chk("count busy", 8'h02, rd);
    edges(0, 1);
    rd16(8'h20);
    chk("count early", 8'h01, cnt[7:0]);
    edges(0, 1);
    rd16(8'h20);
    chk("count written", 8'h05, cnt[7:0]);
    chk("count high", 8'h00, cnt[15:8]);
    cpu_halted_i <= 1'b1;
    edges(0, 3);
    rd16(8'h20);
    chk("halted count", 8'h05, cnt[7:0]);
    wr(8'h14, 8'h01);
    edges(0, 2);
    rd16(8'h20);
    chk("run while halted", 8'h07, cnt[7:0]);
    cpu_halted_i <= 1'b0;
    // Edges on the deselected pin must not move the count.
    for (int s = 1; s < 4; s++) begin
      wr(8'h1C, 8'(s));
      edges(0, 2);
      edges(s, 1);
      rd16(8'h20);
      chk("source step", 8'h07 + 8'(s), cnt[7:0]);
    end
    wr(8'h1C, 8'h00);
    wr(8'h00, 8'h09);
    edges(0, 2);
    rd16(8'h20);
    c = cnt[7:0];
    edges(0, 4);
    rd16(8'h20);
    chk("prescaled", c + 8'h02, cnt[7:0]);
    for (int i = 0; i < 3; i++) begin
      wr(8'h40, {1'b0, tc[i], 3'b001});
      rdb(8'h44);
      chk("tick busy", 8'h01, rd);
      edges(0, 2);
      rdb(8'h44);
      chk("tick idle", 8'h00, rd);
      ticks = 0;
      edges(0, 16);
      chk("tick count", te[i], 8'(ticks));
    end
    wr(8'h40, 8'h08);
    edges(0, 2);
    ticks = 0;
    edges(0, 8);
    chk("tick off", 8'h00, 8'(ticks));
    // Prescaler bits 6 and 3 must be stored; bits 2:1 are written and read back as zero.
    wr(8'h00, 8'hC9);
    rdb(8'h00);
    chk("ctrl readback", 8'hC9, rd);
    final_report();
  end
endmodule // testbench

bind rtc_core rtc_core_monitor u_rtc_core_monitor (.*);
`default_nettype wire
